// ---- core/fault_bank_pkg.sv ----
// Package with register addresses, field positions and reset values.
package fault_bank_pkg;

  // Address fields (five bits between the direction and lock bits).
  localparam logic [4:0] ADDR_OVERCURRENT_9_12 = 5'h1e;
  localparam logic [4:0] ADDR_UNLOADED_1_4     = 5'h01;
  localparam logic [4:0] ADDR_UNLOADED_5_8     = 5'h11;

  // Field position of the address within the address byte.
  localparam int ADDR_FIELD_LSB = 2;
  localparam int ADDR_FIELD_MSB = 6;
  localparam int DIR_BIT_POS    = 7;
  localparam int LOCK_BIT_POS   = 1;
  localparam int TAIL_BIT_POS   = 0;

  // Reset value of every flag register.
  localparam logic [7:0] FLAG_RESET = 8'h00;

  // Default mask of implemented outputs, one bit per switch of 1 to 12.
  localparam logic [23:0] OUTPUTS_PRESENT = 24'hffffff;

endpackage

// ---- core/half_bridge_fault_status_bank.sv ----
// Read-to-clear overcurrent and open-load status bank for twelve bridges.
//
// Summary of operation
// - High-side overcurrent on bridges 9 to 12 latches a 1 and turns it off.
// - Low-side overcurrent on bridges 9 to 12 latches a 1 and turns it off.
// - Overcurrent bits 7 and 6 are bridge 12 high/low, down to 9 low in bit 0.
// - Every flag is 0 after reset, meaning no fault seen.
// - High-side open load on bridges 1 to 8 latches a 1; the switch stays on.
// - Low-side open load on bridges 1 to 8 latches a 1; the switch stays on.
// - Open-load bits 7 down to 0 are bridge 4 high down to bridge 1 low.
// - Open-load bits 7 down to 0 are bridge 8 high down to bridge 5 low.
// - Flags of outputs missing in a smaller variant always read 0.
// - Fields 11110, 00001 and 10001 select the registers; bit 0 must be 1.
// - The global fault flag is the OR of all flags and falls once all clear.
`timescale 1ns/1ps

module half_bridge_fault_status_bank
#(
  parameter logic [23:0] PRESENT = fault_bank_pkg::OUTPUTS_PRESENT
) (
  // Clock and reset.
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  // Fault detector inputs, bit 2k is low side and 2k+1 high side.
  input  wire logic [7:0] overcurrent_9_12_i,
  input  wire logic [7:0] unloaded_1_4_i,
  input  wire logic [7:0] unloaded_5_8_i,
  // Register read port from the serial frame logic.
  input  wire logic       rd_strobe_i,
  input  wire logic [7:0] rd_addr_byte_i,
  output logic      [7:0] rd_data_o,
  output logic            rd_hit_o,
  // Switch disables for bridges 9 to 12, same bit order.
  output logic      [7:0] switch_off_9_12_o,
  // Global fault flag.
  output logic            global_fault_flag_o
);

  import fault_bank_pkg::*;

  // **********************************************************************
  // Address decode.
  // **********************************************************************
  logic [4:0] addr_field;
  logic       frame_ok;
  logic       sel_oc;
  logic       sel_ol_lo;
  logic       sel_ol_hi;

  always_comb begin
    addr_field = rd_addr_byte_i[ADDR_FIELD_MSB:ADDR_FIELD_LSB];
    frame_ok   = rd_strobe_i & rd_addr_byte_i[TAIL_BIT_POS];
    sel_oc     = frame_ok &
                 (addr_field == ADDR_OVERCURRENT_9_12);
    sel_ol_lo  = frame_ok & (addr_field == ADDR_UNLOADED_1_4);
    sel_ol_hi  = frame_ok & (addr_field == ADDR_UNLOADED_5_8);
  end

  // **********************************************************************
  // Flag registers.
  // **********************************************************************
  logic [7:0] oc_r;
  logic [7:0] oc_nxt;
  logic [7:0] ol_lo_r;
  logic [7:0] ol_lo_nxt;
  logic [7:0] ol_hi_r;
  logic [7:0] ol_hi_nxt;
  logic [7:0] oc_set;
  logic [7:0] ol_lo_set;
  logic [7:0] ol_hi_set;
  logic [7:0] rd_data_nxt;
  logic       rd_hit_nxt;
  logic [7:0] off_nxt;
  logic       glob_nxt;

  always_comb begin
    // Absent outputs never set their flag.
    oc_set    = overcurrent_9_12_i & PRESENT[23:16];
    ol_lo_set = unloaded_1_4_i & PRESENT[7:0];
    ol_hi_set = unloaded_5_8_i & PRESENT[15:8];
    // Set wins over the read clear.
    oc_nxt    = (sel_oc ? FLAG_RESET : oc_r) | oc_set;
    ol_lo_nxt = (sel_ol_lo ? FLAG_RESET : ol_lo_r) | ol_lo_set;
    ol_hi_nxt = (sel_ol_hi ? FLAG_RESET : ol_hi_r) | ol_hi_set;
    rd_hit_nxt = sel_oc | sel_ol_lo | sel_ol_hi;
    rd_data_nxt = FLAG_RESET;
    if (sel_oc) begin
      rd_data_nxt = oc_r;
    end else if (sel_ol_lo) begin
      rd_data_nxt = ol_lo_r;
    end else if (sel_ol_hi) begin
      rd_data_nxt = ol_hi_r;
    end
    off_nxt  = oc_nxt;
    glob_nxt = |{oc_nxt, ol_lo_nxt, ol_hi_nxt};
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      oc_r                <= FLAG_RESET;
      ol_lo_r             <= FLAG_RESET;
      ol_hi_r             <= FLAG_RESET;
      rd_data_o           <= FLAG_RESET;
      rd_hit_o            <= 1'b0;
      switch_off_9_12_o   <= FLAG_RESET;
      global_fault_flag_o <= 1'b0;
    end else begin
      oc_r                <= oc_nxt;
      ol_lo_r             <= ol_lo_nxt;
      ol_hi_r             <= ol_hi_nxt;
      rd_data_o           <= rd_data_nxt;
      rd_hit_o            <= rd_hit_nxt;
      switch_off_9_12_o   <= off_nxt;
      global_fault_flag_o <= glob_nxt;
    end
  end

  // **********************************************************************
  // Assertions.
  // **********************************************************************
  a_oc_latch_off: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (oc_set != 8'h00) |=>
    ((switch_off_9_12_o & $past(oc_set)) == $past(oc_set)))
    else $error("Overcurrent did not turn the switch off.");

  a_oc_high_flag: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    oc_set[7] |=> oc_r[7] && switch_off_9_12_o[7])
    else $error("High-side overcurrent flag not latched.");

  a_off_follows: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    switch_off_9_12_o == oc_r)
    else $error("Switch disable differs from overcurrent flags.");

  a_oc_hold: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (oc_r[0] && !sel_oc) |=> oc_r[0])
    else $error("Overcurrent flag lost without a read.");

  a_oc_low_flag: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    oc_set[0] |=> oc_r[0] && switch_off_9_12_o[0])
    else $error("Low-side overcurrent flag not latched.");

  a_oc_read_map: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    sel_oc |=> (rd_data_o == $past(oc_r)) && rd_hit_o)
    else $error("Overcurrent read returned wrong data.");

  a_ol_lo_read: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    sel_ol_lo |=> (rd_data_o == $past(ol_lo_r)) && rd_hit_o)
    else $error("Open-load read for bridges 1 to 4 wrong.");

  a_ol_hi_read: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    sel_ol_hi |=> (rd_data_o == $past(ol_hi_r)) && rd_hit_o)
    else $error("Open-load read for bridges 5 to 8 wrong.");

  a_ol_set_latch: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (ol_hi_set[7] && !sel_ol_hi) |=> ol_hi_r[7] ##1
    (ol_hi_r[7] || $past(sel_ol_hi)))
    else $error("Open-load flag not latched.");

  a_ol_low_latch: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    ol_lo_set[0] |=> ol_lo_r[0])
    else $error("Low-side open-load flag not latched.");

  a_ol_no_off: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (ol_lo_set != 8'h00 && overcurrent_9_12_i == 8'h00 && oc_r == 8'h00
     && switch_off_9_12_o == 8'h00) |=> switch_off_9_12_o == 8'h00)
    else $error("Open load turned a switch off.");

  a_read_clear: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (sel_ol_lo && unloaded_1_4_i == 8'h00) |=> ol_lo_r == 8'h00)
    else $error("Read did not clear open-load flags.");

  a_read_clear_oc: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (sel_oc && overcurrent_9_12_i == 8'h00) |=> oc_r == 8'h00)
    else $error("Read did not clear overcurrent flags.");

  a_absent_zero: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    ((oc_r & ~PRESENT[23:16]) == 8'h00) &&
    ((ol_lo_r & ~PRESENT[7:0]) == 8'h00) &&
    ((ol_hi_r & ~PRESENT[15:8]) == 8'h00))
    else $error("Absent output flag became set.");

  a_global_or: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    global_fault_flag_o == |{oc_r, ol_lo_r, ol_hi_r})
    else $error("Global fault flag differs from flag OR.");

  a_reset_zero: assert property (
    @(posedge sys_clk_i)
    !arst_n_i |-> (oc_r == 8'h00) && (ol_lo_r == 8'h00) &&
    (ol_hi_r == 8'h00) && !global_fault_flag_o)
    else $error("Flags not zero during reset.");

  a_decode_hit: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (rd_strobe_i && !rd_addr_byte_i[0]) |=> !rd_hit_o)
    else $error("Frame without trailing 1 was accepted.");

  a_decode_field: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (rd_strobe_i && rd_addr_byte_i[0] &&
     addr_field == ADDR_UNLOADED_1_4) |=> rd_hit_o)
    else $error("Valid open-load frame was not accepted.");

  a_hit_pulse: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    !rd_strobe_i |=> !rd_hit_o && (rd_data_o == 8'h00))
    else $error("Read answer without a strobe.");

endmodule

// ---- tb/fault_host_model.sv ----
// Host model that issues status reads toward the bank.
`timescale 1ns/1ps
module fault_host_model (
  // Clock and request from the bench.
  input  wire logic       sys_clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] byte_i,
  // Read port toward the bank.
  output logic            rd_strobe_o,
  output logic      [7:0] rd_addr_byte_o
);
  initial rd_strobe_o = 1'b0;
  initial rd_addr_byte_o = 8'h00;
  // Strobe follows go each cycle; an idle address shows inverted junk.
  always @(negedge sys_clk_i) begin
    rd_strobe_o <= go_i;
    rd_addr_byte_o <= go_i ? byte_i : ~rd_addr_byte_o;
  end
endmodule

// ---- tb/half_bridge_fault_status_bank_tb.sv ----
// Self-checking bench for the fault status bank.
`timescale 1ns/1ps
module half_bridge_fault_status_bank_tb;
  import fault_bank_pkg::*;
  logic       sys_clk_i = 1'b0;
  logic       arst_n_i;
  logic [7:0] oc = 8'h00, ol_a = 8'h00, ol_b = 8'h00, rq = 8'h01;
  logic       go = 1'b0, rd_stb, rd_hit, gflag, e_hit = 1'b0;
  logic [7:0] rd_addr, rd_data, sw_off, e_data = 8'h00;
  logic [7:0] m [3] = '{8'h00, 8'h00, 8'h00};
  logic [4:0] fld [3] = '{ADDR_OVERCURRENT_9_12, ADDR_UNLOADED_1_4,
                          ADDR_UNLOADED_5_8};
  int         mismatches = 0, checked = 0, cycles = 0, k;
  always #12.5 sys_clk_i = ~sys_clk_i;
  fault_host_model host_u (.sys_clk_i(sys_clk_i), .go_i(go), .byte_i(rq),
    .rd_strobe_o(rd_stb), .rd_addr_byte_o(rd_addr));
  half_bridge_fault_status_bank dut_u (.sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i), .overcurrent_9_12_i(oc), .unloaded_1_4_i(ol_a),
    .unloaded_5_8_i(ol_b), .rd_strobe_i(rd_stb), .rd_addr_byte_i(rd_addr),
    .rd_data_o(rd_data), .rd_hit_o(rd_hit), .switch_off_9_12_o(sw_off),
    .global_fault_flag_o(gflag));
  task automatic cmp(input string what, input logic [7:0] e, g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Reference: read returns old flags, clears them, set wins.
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      m = '{8'h00, 8'h00, 8'h00};
      e_data = 8'h00;
      e_hit = 1'b0;
    end else begin
      e_hit = 1'b0;
      e_data = 8'h00;
      for (int i = 0; i < 3; i++) begin
        if (rd_stb && rd_addr[0] &&
            rd_addr[ADDR_FIELD_MSB:ADDR_FIELD_LSB] == fld[i]) begin
          e_hit = 1'b1;
          e_data = m[i];
          m[i] = 8'h00;
        end
      end
      m[0] |= oc;
      m[1] |= ol_a;
      m[2] |= ol_b;
    end
  end
  always @(negedge sys_clk_i) begin
    cmp("rd_data_o", e_data, rd_data);
    cmp("rd_hit_o", {7'h00, e_hit}, {7'h00, rd_hit});
    cmp("switch_off_9_12_o", m[0], sw_off);
    cmp("global_flag", {7'h00, |(m[0] | m[1] | m[2])}, {7'h00, gflag});
  end
  always @(negedge sys_clk_i) begin
    cycles++;
    if (cycles > 3000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    arst_n_i = 1'b0;
    void'($urandom(13941));
    repeat (5) @(negedge sys_clk_i);
    arst_n_i <= 1'b1;
    $display("test reset done");
    repeat (800) begin
      @(negedge sys_clk_i);
      k = $urandom_range(3, 0);
      oc <= ($urandom % 5 == 0) ? 8'($urandom) : 8'h00;
      ol_a <= ($urandom % 5 == 0) ? 8'($urandom) : 8'h00;
      ol_b <= ($urandom % 5 == 0) ? 8'($urandom) : 8'h00;
      go <= 1'($urandom);
      rq <= {1'($urandom), (k < 3) ? fld[k] : 5'($urandom), 1'($urandom),
             1'($urandom % 4 != 0)};
      if (cycles == 400) arst_n_i <= 1'b0;
      if (cycles == 403) arst_n_i <= 1'b1;
    end
    $display("test random traffic done");
    @(negedge sys_clk_i);
    {oc, ol_a, ol_b} <= 24'hffffff;
    go <= 1'b0;
    @(negedge sys_clk_i);
    {oc, ol_a, ol_b} <= 24'h000000;
    for (int j = 0; j < 6; j++) begin
      go <= 1'b1;
      rq <= {1'b0, fld[j % 3], 1'b0, 1'b1};
      @(negedge sys_clk_i);
    end
    go <= 1'b0;
    repeat (4) @(negedge sys_clk_i);
    $display("test back to back reads done");
    end_of_test();
  end
endmodule
